// >>> rtcc_pkg.sv
// Shared constants for the calendar timekeeping core
package rtcc_pkg;
   // Register byte offsets on the Avalon-MM bus
   localparam logic [5:0] OFS_SECONDS = 6'h00;
   localparam logic [5:0] OFS_MINUTES = 6'h04;
   localparam logic [5:0] OFS_HOURS = 6'h08;
   localparam logic [5:0] OFS_WEEKDAY = 6'h0C;
   localparam logic [5:0] OFS_DATE = 6'h10;
   localparam logic [5:0] OFS_MONTH = 6'h14;
   localparam logic [5:0] OFS_YEAR = 6'h18;
   localparam logic [5:0] OFS_CONTROL = 6'h1C;
   localparam logic [5:0] OFS_TRICKLE = 6'h20;
   localparam logic [5:0] OFS_FLAG = 6'h24;
   localparam logic [5:0] OFS_POWER = 6'h28;
   localparam logic [5:0] OFS_IRQ_STATUS = 6'h2C;
   localparam logic [5:0] OFS_IRQ_MASK = 6'h30;
   // Field positions
   localparam int BIT_HALT = 7;
   localparam int BIT_LEVEL = 7;
   localparam int BIT_SQW = 6;
   localparam int BIT_STOP = 7;
   localparam int BIT_PWR_BACKUP = 0;
   localparam int BIT_PWR_READY = 1;
   localparam int IRQ_SECOND = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_POWER = 2;
   // Reset values
   localparam logic [7:0] RST_CONTROL = 8'h80;
   localparam logic [7:0] RST_TRICKLE = 8'h00;
   localparam logic [7:0] RST_FLAG = 8'h80;
   // Trickle-charge select codes
   localparam logic [7:0] TRK_R250 = 8'hA5;
   localparam logic [7:0] TRK_R2000 = 8'hA6;
   localparam logic [7:0] TRK_R4000 = 8'hA7;
   // Time base
   localparam int CRYSTAL_HZ = 32768;
   localparam int SQW_HZ = 512;
   localparam int SQW_HALF = CRYSTAL_HZ / SQW_HZ / 2;
   localparam int STOP_CYC = 1024;
   // Recovery time after power returns, in microseconds
   localparam int RECOVERY_US = 2000;
   localparam int MCLK_MHZ = 200;
   localparam int RECOVERY_CYC = RECOVERY_US * MCLK_MHZ;
endpackage : rtcc_pkg

// >>> rtcc_edge.sv
// Two-flop synchroniser with rising-edge pulse
`timescale 1ns/10ps
module rtcc_edge #(
   // Level held in reset; match the pin's idle level to avoid a false edge
   parameter logic RESET_LEVEL = 1'b0
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Asynchronous level in, synced level and rising pulse out
   input wire logic async_i,
   output logic level_o,
   output logic rise_o
);
   logic meta;
   logic sync;
   logic last;
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= RESET_LEVEL;
         sync <= RESET_LEVEL;
         last <= RESET_LEVEL;
      end else begin
         meta <= async_i;
         sync <= meta;
         last <= sync;
      end
   end
   assign level_o = sync;
   assign rise_o = sync & ~last;
endmodule : rtcc_edge

// >>> rtcc_cal.sv
// Calendar arithmetic for one counter stage
`timescale 1ns/10ps
module rtcc_cal (
   // Current month and year, binary
   input wire logic [3:0] month_i,
   input wire logic [6:0] year_i,
   // Last valid date of the month
   output logic [4:0] last_day_o
);
   wire leap = (year_i[1:0] == 2'b00);
   wire short30 = (month_i == 4'd4) || (month_i == 4'd6) ||
                  (month_i == 4'd9) || (month_i == 4'd11);
   wire feb = (month_i == 4'd2);
   assign last_day_o = feb ? (leap ? 5'd29 : 5'd28) :
                       (short30 ? 5'd30 : 5'd31); // [R2]
endmodule : rtcc_cal

// >>> rtcc_core.sv
// Timekeeping core: calendar, test/level pin, power and trickle logic
`timescale 1ns/10ps
// What this block does
// [R1] Seconds through years cascade, each stage carried by the one below.
// [R2] Date wraps at the month's real last day, February 29 in leap years.
// [R3] Square-wave select high: pin toggles at 512Hz from the crystal.
// [R4] Square-wave select low: pin shows the static level bit.
// [R5] Pin is open drain: pulls low for 0, released for 1, any supply.
// [R6] Host waits up to 2 ms after power returns before access.
// [R7] Recovery delay only while oscillator enabled and running.
// [R8] Stop flag set once oscillator stopped for the minimum period.
// [R9] Codes A5h, A6h, A7h pick the small, middle, large resistor.
// [R10] Software never picks the 250 ohm path above 3.63V supply.
// [R11] On main power loss switch to secondary supply, counters keep running.
// [R12] Two-wire serial bus with open-drain data and external pull-up; the core has an Avalon-MM slave instead.
// [R13] Level bit 7 resets 1, square-wave select bit 6 resets 0.
// [R14] Halt bit 7 of seconds register stops oscillator, resets 0.
// [R15] Three trickle resistors nominally 250, 2000 and 4000 ohms.
// [R16] One-second tick from dividing the crystal by 32768.
// [R17] Stop flag stays set until software writes it to zero.
module rtcc_core #(
   parameter int RECOVERY_CYCLES = rtcc_pkg::RECOVERY_CYC,
   parameter int STOP_CYCLES = rtcc_pkg::STOP_CYC,
   parameter int TICK_DIV = rtcc_pkg::CRYSTAL_HZ
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Crystal time base and main supply sense
   input wire logic crystal_in_i,
   input wire logic main_power_good_i,
   // Test/level pin, open drain
   input wire logic test_level_pin_i,
   output logic test_level_pin_o,
   output logic test_level_pin_oe_o,
   // Supply and charger control
   output logic secondary_supply_sel_o,
   output logic [2:0] trickle_res_sel_o,
   output logic crystal_drive_en_o,
   // Interrupt
   output logic irq_o
);
   logic [14:0] div;
   logic [5:0] sec;
   logic [5:0] min;
   logic [4:0] hour;
   logic [2:0] wday;
   logic [4:0] date;
   logic [3:0] month;
   logic [6:0] year;
   logic [7:0] control;
   logic [7:0] trickle;
   logic stop_flag;
   logic halt;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [31:0] rdata;
   logic ack;
   logic pin_q;
   logic [5:0] sqw_cnt;
   logic [$clog2(STOP_CYCLES+1)-1:0] stop_cnt;
   logic [$clog2(RECOVERY_CYCLES+1)-1:0] rec_cnt;
   logic xtal_lvl;
   logic xtal_rise;
   logic pwr_lvl;
   logic pwr_rise;
   logic pwr_last;
   logic [4:0] last_day;

   // Crystal and supply sense cross into the bus clock
   rtcc_edge u_xtal (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(crystal_in_i),
      .level_o(xtal_lvl),
      .rise_o(xtal_rise)
   );
   // Main supply idles high; starting high keeps reset from faking a return
   rtcc_edge #(.RESET_LEVEL(1'b1)) u_pwr (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .async_i(main_power_good_i),
      .level_o(pwr_lvl),
      .rise_o(pwr_rise)
   );
   rtcc_cal u_cal (
      .month_i(month),
      .year_i(year),
      .last_day_o(last_day)
   );

   // Bus decode; one wait cycle so the master samples waitrequest low once
   wire acc = (avs_read_i | avs_write_i) & ~ack;
   wire wr = avs_write_i & ~ack;
   wire [7:0] wd = avs_writedata_i[7:0];
   wire wr_sec = wr && avs_address_i == rtcc_pkg::OFS_SECONDS;
   wire wr_min = wr && avs_address_i == rtcc_pkg::OFS_MINUTES;
   wire wr_hour = wr && avs_address_i == rtcc_pkg::OFS_HOURS;
   wire wr_wday = wr && avs_address_i == rtcc_pkg::OFS_WEEKDAY;
   wire wr_date = wr && avs_address_i == rtcc_pkg::OFS_DATE;
   wire wr_month = wr && avs_address_i == rtcc_pkg::OFS_MONTH;
   wire wr_year = wr && avs_address_i == rtcc_pkg::OFS_YEAR;
   wire wr_ctl = wr && avs_address_i == rtcc_pkg::OFS_CONTROL;
   wire wr_trk = wr && avs_address_i == rtcc_pkg::OFS_TRICKLE;
   wire wr_flag = wr && avs_address_i == rtcc_pkg::OFS_FLAG;
   wire wr_ist = wr && avs_address_i == rtcc_pkg::OFS_IRQ_STATUS;
   wire wr_imask = wr && avs_address_i == rtcc_pkg::OFS_IRQ_MASK;

   // Oscillator runs while not halted, on main or secondary supply alike
   wire osc_run = ~halt; // [R11]
   wire tick_in = xtal_rise & osc_run;
   wire sec_tick = tick_in && div == 15'(TICK_DIV - 1); // [R16]
   wire c_sec = sec_tick && sec == 6'd59; // [R1]
   wire c_min = c_sec && min == 6'd59;
   wire c_hour = c_min && hour == 5'd23;
   wire c_date = c_hour && date == last_day; // [R2]
   wire c_month = c_date && month == 4'd12;
   wire stop_now = stop_cnt == STOP_CYCLES[$bits(stop_cnt)-1:0];
   wire stop_evt = stop_now & ~stop_flag;
   wire pwr_fall = ~pwr_lvl & pwr_last;
   wire [2:0] irq_set = {pwr_fall | pwr_rise, stop_evt, sec_tick};
   wire ready = rec_cnt == '0;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div <= '0;
      end else if (wr_sec) begin
         div <= '0;
      end else if (sec_tick) begin
         div <= '0; // [R16]
      end else if (tick_in) begin
         div <= div + 15'd1; // [R16]
      end
   end

   // Counters: a bus write to a field wins over the carry that cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sec <= '0;
         min <= '0;
         hour <= '0;
         wday <= 3'd1;
         date <= 5'd1;
         month <= 4'd1;
         year <= '0;
         halt <= 1'b0; // [R14]
      end else begin
         if (wr_sec) begin
            sec <= wd[5:0];
            halt <= wd[rtcc_pkg::BIT_HALT]; // [R14]
         end else if (sec_tick) begin
            sec <= c_sec ? 6'd0 : sec + 6'd1; // [R1]
         end
         if (wr_min) min <= wd[5:0];
         else if (c_sec) min <= c_min ? 6'd0 : min + 6'd1;
         if (wr_hour) hour <= wd[4:0];
         else if (c_min) hour <= c_hour ? 5'd0 : hour + 5'd1;
         if (wr_wday) wday <= wd[2:0];
         else if (c_hour) wday <= (wday == 3'd7) ? 3'd1 : wday + 3'd1;
         if (wr_date) date <= wd[4:0];
         else if (c_hour) date <= c_date ? 5'd1 : date + 5'd1; // [R2]
         if (wr_month) month <= wd[3:0];
         else if (c_date) month <= c_month ? 4'd1 : month + 4'd1;
         if (wr_year) year <= wd[6:0];
         else if (c_month) year <= (year == 7'd99) ? 7'd0 : year + 7'd1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         control <= rtcc_pkg::RST_CONTROL; // [R13]
         trickle <= rtcc_pkg::RST_TRICKLE;
         irq_mask <= '0;
      end else begin
         if (wr_ctl) control <= wd;
         if (wr_trk) trickle <= wd; // [R9]
         if (wr_imask) irq_mask <= avs_writedata_i[2:0];
      end
   end

   // Stop detect: a crystal edge restarts the count, halt lets it run
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_cnt <= '0;
      end else if (xtal_rise && osc_run) begin
         stop_cnt <= '0;
      end else if (!stop_now) begin
         stop_cnt <= stop_cnt + 1'b1;
      end
   end

   // Set wins over the clear written in the same cycle
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stop_flag <= rtcc_pkg::RST_FLAG[rtcc_pkg::BIT_STOP];
         irq_status <= '0;
      end else begin
         if (stop_now) stop_flag <= 1'b1; // [R8]
         else if (wr_flag && !wd[rtcc_pkg::BIT_STOP]) stop_flag <= 1'b0; // [R17]
         irq_status <= irq_set | (irq_status &
                       ~(wr_ist ? avs_writedata_i[2:0] : 3'b000));
      end
   end

   // Recovery delay after power returns, only if the oscillator runs
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rec_cnt <= '0;
         pwr_last <= 1'b1;
      end else begin
         pwr_last <= pwr_lvl;
         if (pwr_rise && osc_run && !stop_flag) begin
            rec_cnt <= RECOVERY_CYCLES[$bits(rec_cnt)-1:0]; // [R7]
         end else if (!osc_run || !pwr_lvl) begin
            rec_cnt <= '0; // [R7]
         end else if (!ready) begin
            rec_cnt <= rec_cnt - 1'b1; // [R6]
         end
      end
   end

   // 512Hz square wave: 32 crystal edges per half period
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sqw_cnt <= '0;
         pin_q <= 1'b1;
      end else if (!control[rtcc_pkg::BIT_SQW]) begin
         sqw_cnt <= '0;
         pin_q <= control[rtcc_pkg::BIT_LEVEL]; // [R4]
      end else if (tick_in) begin
         if (sqw_cnt == 6'(rtcc_pkg::SQW_HALF - 1)) begin
            sqw_cnt <= '0;
            pin_q <= ~pin_q; // [R3]
         end else begin
            sqw_cnt <= sqw_cnt + 6'd1;
         end
      end
   end

   always_comb begin
      case (avs_address_i)
         rtcc_pkg::OFS_SECONDS: rdata = {24'h0, halt, 1'b0, sec};
         rtcc_pkg::OFS_MINUTES: rdata = {26'h0, min};
         rtcc_pkg::OFS_HOURS: rdata = {27'h0, hour};
         rtcc_pkg::OFS_WEEKDAY: rdata = {29'h0, wday};
         rtcc_pkg::OFS_DATE: rdata = {27'h0, date};
         rtcc_pkg::OFS_MONTH: rdata = {28'h0, month};
         rtcc_pkg::OFS_YEAR: rdata = {25'h0, year};
         rtcc_pkg::OFS_CONTROL: rdata = {24'h0, control};
         rtcc_pkg::OFS_TRICKLE: rdata = {24'h0, trickle};
         rtcc_pkg::OFS_FLAG: rdata = {24'h0, stop_flag, 7'h0};
         rtcc_pkg::OFS_POWER: rdata = {30'h0, ready, ~pwr_lvl};
         rtcc_pkg::OFS_IRQ_STATUS: rdata = {29'h0, irq_status};
         rtcc_pkg::OFS_IRQ_MASK: rdata = {29'h0, irq_mask};
         default: rdata = 32'h0000_0000;
      endcase
   end

   // Outputs registered; waitrequest held high until the access is ready
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack <= 1'b0;
         avs_readdata_o <= '0;
         avs_waitrequest_o <= 1'b1;
         test_level_pin_o <= 1'b0;
         test_level_pin_oe_o <= 1'b0;
         secondary_supply_sel_o <= 1'b0;
         trickle_res_sel_o <= '0;
         crystal_drive_en_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         ack <= acc;
         avs_waitrequest_o <= ~acc;
         if (acc) avs_readdata_o <= rdata; // [R12]
         test_level_pin_o <= 1'b0;
         test_level_pin_oe_o <= ~pin_q; // [R5]
         secondary_supply_sel_o <= ~pwr_lvl; // [R11]
         trickle_res_sel_o <= {trickle == rtcc_pkg::TRK_R4000,
                               trickle == rtcc_pkg::TRK_R2000,
                               trickle == rtcc_pkg::TRK_R250}; // [R9] [R15]
         crystal_drive_en_o <= osc_run;
         irq_o <= |(irq_status & irq_mask);
      end
   end

   a_flag_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      stop_flag && !wr_flag |=> stop_flag) // [R17]
      else $error("stop flag dropped without a write");
   a_flag_sets: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      stop_now |=> stop_flag) // [R8]
      else $error("stop flag not set after stop period");
   a_pin_level: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !control[rtcc_pkg::BIT_SQW] ##2 !control[rtcc_pkg::BIT_SQW]
      |-> test_level_pin_oe_o == ~$past(control[rtcc_pkg::BIT_LEVEL], 2))
      // [R4]
      else $error("pin does not follow level bit");
   a_pin_drain: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      test_level_pin_o == 1'b0) // [R5]
      else $error("pin driven high");
   a_sec_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      c_sec && !wr_sec && !wr_min |=> sec == 6'd0 &&
      min == ($past(min) == 6'd59 ? 6'd0 : $past(min) + 6'd1)) // [R1]
      else $error("seconds carry wrong");
   a_date_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      c_date && !wr_date |=> date == 5'd1) // [R2]
      else $error("date did not wrap at month end");
   a_trk_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      trickle == rtcc_pkg::TRK_R250 ##1 1'b1 |-> trickle_res_sel_o == 3'b001)
      // [R9]
      else $error("trickle select wrong");
   a_rec_skip: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !osc_run |=> ready) // [R7]
      else $error("recovery delay with oscillator halted");
   a_backup_sel: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      !pwr_lvl |=> secondary_supply_sel_o) // [R11]
      else $error("no switch to secondary supply");
   a_tick_div: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      sec_tick |=> div == 15'h0000) // [R16]
      else $error("divider did not wrap on tick");
endmodule : rtcc_core

// >>> rtcc_xtal_model.sv
// Crystal time base and the pulled-up test/level line outside the core
`timescale 1ns/10ps
module rtcc_xtal_model #(
   parameter int HALF_NS = 32
) (
   // Crystal controls
   input wire logic run_i,
   input wire logic drive_en_i,
   // Pin enable from the core
   input wire logic pin_oe_i,
   // Crystal and resolved pin level
   output logic xtal_o,
   output logic pin_o
);
   initial xtal_o = 1'b0;
   // A halted or failed crystal freezes in place, as a real one does
   always begin
      #(HALF_NS);
      if (run_i && drive_en_i) begin
         xtal_o = ~xtal_o;
      end
   end
   // External pull-up: the line is high unless the core pulls it low
   assign pin_o = pin_oe_i ? 1'b0 : 1'b1;
endmodule : rtcc_xtal_model

// >>> rtcc_core_tb.sv
// Self-checking bench for the calendar timekeeping core
`timescale 1ns/10ps
module rtcc_core_tb;
   localparam int REC_CYC = 50;
   localparam int STP_CYC = 64;
   localparam int CEIL = 20000;
   // Short second so that calendar carries fit in the run
   localparam int TICK_DIV = 4;
   localparam logic [7:0] CODES [5] = '{rtcc_pkg::TRK_R250,
      rtcc_pkg::TRK_R2000, rtcc_pkg::TRK_R4000, 8'hA4, 8'h00};
   localparam logic [2:0] SELS [5] = '{3'b001, 3'b010, 3'b100, 3'b000, 3'b000};
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [5:0] avs_address_i = 6'h00;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic crystal_in_i;
   logic main_power_good_i = 1'b1;
   logic test_level_pin_i;
   logic test_level_pin_o;
   logic test_level_pin_oe_o;
   logic secondary_supply_sel_o;
   logic [2:0] trickle_res_sel_o;
   logic crystal_drive_en_o;
   logic irq_o;
   logic xtal_run = 1'b1;
   logic [31:0] rd;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   always #2.5 mclk_i = ~mclk_i;
   rtcc_core #(.RECOVERY_CYCLES(REC_CYC), .STOP_CYCLES(STP_CYC),
      .TICK_DIV(TICK_DIV)) u_rtcc_core (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .crystal_in_i(crystal_in_i),
      .main_power_good_i(main_power_good_i),
      .test_level_pin_i(test_level_pin_i), .test_level_pin_o(test_level_pin_o),
      .test_level_pin_oe_o(test_level_pin_oe_o),
      .secondary_supply_sel_o(secondary_supply_sel_o),
      .trickle_res_sel_o(trickle_res_sel_o),
      .crystal_drive_en_o(crystal_drive_en_o), .irq_o(irq_o));
   rtcc_xtal_model #(.HALF_NS(32)) u_rtcc_xtal_model (
      .run_i(xtal_run), .drive_en_i(crystal_drive_en_o),
      .pin_oe_i(test_level_pin_oe_o), .xtal_o(crystal_in_i),
      .pin_o(test_level_pin_i));
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic cycles(input int k);
      repeat (k) @(posedge mclk_i);
   endtask : cycles
   // Holds the request until waitrequest is sampled low, then releases
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= ~wr;
      do begin
         @(posedge mclk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      // One wait cycle per access; a hang is left to the bench timeout
      chk("bus wait cycles", 32'h0000_0002, n);
   endtask : bus
   task automatic rdchk(input string what, input logic [5:0] a,
                        input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, exp, rd);
   endtask : rdchk
   task automatic pin_change(output int n);
      logic last;
      last = test_level_pin_oe_o;
      n = 0;
      while (test_level_pin_oe_o === last && n < 1000) begin
         @(posedge mclk_i);
         n++;
      end
   endtask : pin_change
   task automatic test_reset();
      rdchk("control", rtcc_pkg::OFS_CONTROL, 32'h0000_0080);
      rdchk("trickle", rtcc_pkg::OFS_TRICKLE, 32'h0000_0000);
      rdchk("seconds", rtcc_pkg::OFS_SECONDS, 32'h0000_0000);
      rdchk("unmapped", 6'h3C, 32'h0000_0000);
      // No power-change event may follow reset with main supply present
      rdchk("irq status", rtcc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
      chk("pin enable", 32'h0, test_level_pin_oe_o);
      chk("pin out", 32'h0, test_level_pin_o);
      chk("drive enable", 32'h1, crystal_drive_en_o);
      $display("[DONE] reset values");
   endtask : test_reset
   task automatic test_level();
      bus(1'b1, rtcc_pkg::OFS_CONTROL, 32'h0000_0000);
      cycles(3);
      chk("pin level low", 32'h0, test_level_pin_i);
      bus(1'b1, rtcc_pkg::OFS_CONTROL, 32'h0000_0080);
      cycles(3);
      chk("pin level high", 32'h1, test_level_pin_i);
      $display("[DONE] static level");
   endtask : test_level
   task automatic test_square();
      int n;
      int exp;
      // Half period is a whole number of crystal periods, +-sync jitter
      exp = 64 * rtcc_pkg::SQW_HALF / 5;
      bus(1'b1, rtcc_pkg::OFS_CONTROL, 32'h0000_0040);
      pin_change(n);
      pin_change(n);
      chk("square half", 32'h1, n >= exp - 2 && n <= exp + 2);
      pin_change(n);
      chk("square half", 32'h1, n >= exp - 2 && n <= exp + 2);
      bus(1'b1, rtcc_pkg::OFS_CONTROL, 32'h0000_0080);
      $display("[DONE] square wave");
   endtask : test_square
   task automatic test_trickle();
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, rtcc_pkg::OFS_TRICKLE, {24'h0, CODES[i]});
         cycles(2);
         chk("trickle sel", {29'h0, SELS[i]}, trickle_res_sel_o);
      end
      $display("[DONE] trickle codes");
   endtask : test_trickle
   task automatic test_stop();
      // Stop the crystal first so no second tick lands after the clear
      xtal_run <= 1'b0;
      bus(1'b1, rtcc_pkg::OFS_FLAG, 32'h0000_0000);
      bus(1'b1, rtcc_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      rdchk("flag cleared", rtcc_pkg::OFS_FLAG, 32'h0000_0000);
      cycles(STP_CYC + 20);
      rdchk("flag set", rtcc_pkg::OFS_FLAG, 32'h0000_0080);
      rdchk("stop event", rtcc_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
      bus(1'b1, rtcc_pkg::OFS_IRQ_MASK, 32'h0000_0002);
      cycles(2);
      chk("irq raised", 32'h1, irq_o);
      xtal_run <= 1'b1;
      cycles(20);
      rdchk("flag sticky", rtcc_pkg::OFS_FLAG, 32'h0000_0080);
      bus(1'b1, rtcc_pkg::OFS_FLAG, 32'h0000_0000);
      rdchk("flag clear", rtcc_pkg::OFS_FLAG, 32'h0000_0000);
      bus(1'b1, rtcc_pkg::OFS_IRQ_STATUS, 32'h0000_0002);
      cycles(2);
      chk("irq cleared", 32'h0, irq_o);
      bus(1'b1, rtcc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      $display("[DONE] stop flag");
   endtask : test_stop
   task automatic power_cycle();
      main_power_good_i <= 1'b0;
      cycles(8);
      chk("on secondary", 32'h1, secondary_supply_sel_o);
      bus(1'b0, rtcc_pkg::OFS_POWER, 32'h0000_0000);
      chk("backup bit", 32'h1, rd[rtcc_pkg::BIT_PWR_BACKUP]);
      main_power_good_i <= 1'b1;
      cycles(8);
      chk("on main", 32'h0, secondary_supply_sel_o);
      bus(1'b0, rtcc_pkg::OFS_POWER, 32'h0000_0000);
   endtask : power_cycle
   task automatic test_power();
      power_cycle();
      chk("recovering", 32'h0, rd[rtcc_pkg::BIT_PWR_READY]);
      cycles(REC_CYC);
      bus(1'b0, rtcc_pkg::OFS_POWER, 32'h0000_0000);
      chk("recovered", 32'h1, rd[rtcc_pkg::BIT_PWR_READY]);
      bus(1'b1, rtcc_pkg::OFS_SECONDS, 32'h0000_0080);
      cycles(2);
      chk("drive halted", 32'h0, crystal_drive_en_o);
      cycles(STP_CYC + 20);
      power_cycle();
      chk("no delay", 32'h1, rd[rtcc_pkg::BIT_PWR_READY]);
      bus(1'b1, rtcc_pkg::OFS_SECONDS, 32'h0000_0000);
      cycles(2);
      chk("drive running", 32'h1, crystal_drive_en_o);
      $display("[DONE] power switch");
   endtask : test_power
   // One second before midnight, then read the day after one tick
   task automatic cal_step(input logic [7:0] y, input logic [7:0] m,
                           input logic [7:0] d, input logic [7:0] ey,
                           input logic [7:0] em, input logic [7:0] ed);
      // Seconds first restart the divider, so no carry meets the writes
      bus(1'b1, rtcc_pkg::OFS_SECONDS, 32'h0000_003B);
      bus(1'b1, rtcc_pkg::OFS_MINUTES, 32'h0000_003B);
      bus(1'b1, rtcc_pkg::OFS_HOURS, 32'h0000_0017);
      bus(1'b1, rtcc_pkg::OFS_WEEKDAY, 32'h0000_0007);
      bus(1'b1, rtcc_pkg::OFS_DATE, {24'h0, d});
      bus(1'b1, rtcc_pkg::OFS_MONTH, {24'h0, m});
      bus(1'b1, rtcc_pkg::OFS_YEAR, {24'h0, y});
      bus(1'b1, rtcc_pkg::OFS_IRQ_STATUS, 32'h0000_0007);
      // Tick comes 38 to 52 cycles after the seconds write, the next after 89
      cycles(39);
      rdchk("hours", rtcc_pkg::OFS_HOURS, 32'h0000_0000);
      rdchk("weekday", rtcc_pkg::OFS_WEEKDAY, 32'h0000_0001);
      rdchk("date", rtcc_pkg::OFS_DATE, {24'h0, ed});
      rdchk("month", rtcc_pkg::OFS_MONTH, {24'h0, em});
      rdchk("year", rtcc_pkg::OFS_YEAR, {24'h0, ey});
      rdchk("tick event", rtcc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
   endtask : cal_step
   task automatic test_calendar();
      cal_step(8'h04, 8'h02, 8'h1C, 8'h04, 8'h02, 8'h1D);
      cal_step(8'h63, 8'h02, 8'h1C, 8'h63, 8'h03, 8'h01);
      cal_step(8'h05, 8'h04, 8'h1E, 8'h05, 8'h05, 8'h01);
      cal_step(8'h63, 8'h0C, 8'h1F, 8'h00, 8'h01, 8'h01);
      $display("[DONE] calendar carries");
   endtask : test_calendar
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == CEIL) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      test_reset();
      test_level();
      test_square();
      test_trickle();
      test_stop();
      test_power();
      test_calendar();
      conclude();
   end
endmodule : rtcc_core_tb
